// file: asc_pkg.sv
// constants shared by the synchronous channel port design
package asc_pkg;

  // ----------------------------------------------------------------
  // clocking and rate generation
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned REF_HZ = 4_096_000;
  localparam int unsigned EXT_X16_MAX_HZ = 2_100_000;
  localparam int unsigned EXT_BPS_MAX = 128_000;
  localparam int unsigned ACC_W = 23;

  // ----------------------------------------------------------------
  // link framing
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG_WORD = 8'h7E;
  localparam logic [3:0] LEN_SHORT = 4'h8;
  localparam logic [3:0] LEN_LONG = 4'h9;
  localparam logic [3:0] BITS_PER_WINDOW = 4'h8;
  localparam logic [2:0] BACKLOG_LEVEL = 3'h2;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned WORD_W = 9;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_STATUS = 5'h04;
  localparam logic [4:0] ADR_TXDATA = 5'h08;
  localparam logic [4:0] ADR_RXDATA = 5'h0C;
  localparam logic [4:0] ADR_IRQ_STAT = 5'h10;
  localparam logic [4:0] ADR_IRQ_MASK = 5'h14;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_RATE_LSB = 1;
  localparam int unsigned CTRL_LEN_BIT = 4;
  localparam int unsigned IRQ_RX_WORD = 0;
  localparam int unsigned IRQ_FRAMED = 1;
  localparam int unsigned IRQ_OVERRUN = 2;
  localparam int unsigned IRQ_TX_EMPTY = 3;

  // x16 sampling rate for each divided rate code
  function automatic logic [ACC_W-1:0] x16_step(input logic [2:0] code);
    case (code)
      3'h1: x16_step = 23'd614400;
      3'h2: x16_step = 23'd307200;
      3'h3: x16_step = 23'd153600;
      3'h4: x16_step = 23'd76800;
      3'h5: x16_step = 23'd38400;
      3'h6: x16_step = 23'd19200;
      3'h7: x16_step = 23'd4800;
      default: x16_step = 23'd0;
    endcase
  endfunction : x16_step

endpackage : asc_pkg

// file: asc_sync.sv
// two-flop synchroniser with a third stage for edge detection
`timescale 1ns/10ps
`default_nettype none
module asc_sync #(
  parameter int unsigned W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] prev_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  logic [W-1:0] prev_r;

  // ----------------------------------------------------------------
  // stages; meta_r feeds q_r only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
      prev_r <= q_r;
    end
  end

  assign q_o = q_r;
  assign prev_o = prev_r;

endmodule : asc_sync
`default_nettype wire

// file: asc_rate_gen.sv
// x16 sampling enable from the rate reference input
`timescale 1ns/10ps
`default_nettype none
module asc_rate_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_edge_i,
  input wire logic [2:0] rate_sel_i,
  output logic x16_o
);

  logic [asc_pkg::ACC_W-1:0] acc_r;
  logic [asc_pkg::ACC_W-1:0] acc_nxt;
  logic [asc_pkg::ACC_W:0] sum;
  logic x16_r;
  logic x16_nxt;

  // ----------------------------------------------------------------
  // fractional divider: exact on average, jitter of one ref period
  // ----------------------------------------------------------------
  always_comb begin
    acc_nxt = acc_r;
    x16_nxt = 1'b0;
    sum = {1'b0, acc_r} + {1'b0, asc_pkg::x16_step(rate_sel_i)};
    if (ref_edge_i) begin
      if (rate_sel_i == 3'h0) begin
        x16_nxt = 1'b1;
      end else if (sum >= (asc_pkg::ACC_W+1)'(asc_pkg::REF_HZ)) begin
        acc_nxt = asc_pkg::ACC_W'(sum - (asc_pkg::ACC_W+1)'(asc_pkg::REF_HZ));
        x16_nxt = 1'b1;
      end else begin
        acc_nxt = asc_pkg::ACC_W'(sum);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= '0;
      x16_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      x16_r <= x16_nxt;
    end
  end

  assign x16_o = x16_r;

endmodule : asc_rate_gen
`default_nettype wire

// file: asc_port.sv
// synchronous channel port with wishbone registers and rate generator
// Notes on behaviour
// - reset low empties both fifos, drives backlog and framing flags low
// - after reset no received word enters the rx fifo before a flag
// - input bits are captured on data clock falls only inside input window; the code also samples at window open with clock low or close with clock high
// - rate code zero uses the reference clock directly as x16 clock
// - codes one to seven divide a 4.096 MHz reference to x16 rates
// - edge mode low samples when data clock low meets input window high
// - edge mode low advances output when data clock and window stop both high
// - edge mode high samples on falling edge of data clock and input window
// - serial output driven only while the output window enable is high
// - edge mode low shows a new bit after each clock fall in the window
// - edge mode high shows a new bit after each of the first eight clock rises in the window
// - edge mode low keeps a pending bit for the next window's first bit
// - framing flag word is 01111110
// - edge mode high sends at most eight bits per output window
// - word length select picks nine-bit words high, eight-bit low
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module asc_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic reset_n_i,
  input wire logic sync_bit_clock_i,
  input wire logic input_window_enable_i,
  input wire logic output_window_enable_i,
  input wire logic sync_serial_in_i,
  output logic sync_serial_out_o,
  output logic sync_serial_out_oe_n_o,
  input wire logic rate_reference_clock_i,
  output logic x16_sampling_clock_o,
  output logic tx_backlog_flag_o,
  output logic rx_framing_flag_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0][8:0] txm;
    logic [1:0] twp;
    logic [1:0] trp;
    logic [2:0] tcnt;
    logic [3:0][8:0] rxm;
    logic [1:0] rwp;
    logic [1:0] rrp;
    logic [2:0] rcnt;
    logic [8:0] tsh;
    logic [3:0] tleft;
    logic tout;
    logic [3:0] wbits;
    logic [7:0] hunt;
    logic framed;
    logic [8:0] rword;
    logic [3:0] rbits;
    logic [4:0] ctrl;
    logic [3:0] ists;
    logic [3:0] imask;
    logic ack;
    logic [31:0] rdat;
    logic oe;
  } asc_state_t;

  asc_state_t s_r;
  asc_state_t s_nxt;

  logic [4:0] lnk_q;
  logic [4:0] lnk_p;
  logic dc, input_window_enable, output_window_enable, din, refc;
  logic dcp, diep, doep, refp;

  // ----------------------------------------------------------------
  // link input synchroniser and rate generator
  // ----------------------------------------------------------------
  asc_sync #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({rate_reference_clock_i, sync_serial_in_i, output_window_enable_i,
          input_window_enable_i, sync_bit_clock_i}),
    .q_o(lnk_q),
    .prev_o(lnk_p)
  );

  // strobe edges come from synchronised samples only
  assign {refc, din, output_window_enable, input_window_enable, dc} = lnk_q;
  assign {refp, dcp} = {lnk_p[4], lnk_p[0]};
  assign diep = lnk_p[1];
  assign doep = lnk_p[2];

  asc_rate_gen u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ref_edge_i(refc & ~refp),
    .rate_sel_i(s_r.ctrl[asc_pkg::CTRL_RATE_LSB +: 3]),
    .x16_o(x16_sampling_clock_o)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic hold;
  logic mode;
  logic [3:0] len;
  logic rx_evt;
  logic tx_adv;
  logic t_push, t_pop, r_push, r_pop;
  logic bus_go;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [8:0] wnew;

  always_comb begin
    s_nxt = s_r;
    hold = ~reset_n_i;
    mode = s_r.ctrl[asc_pkg::CTRL_MODE_BIT];
    len = s_r.ctrl[asc_pkg::CTRL_LEN_BIT] ? asc_pkg::LEN_LONG : asc_pkg::LEN_SHORT;
    bus_go = cyc_i & stb_i & ~s_r.ack;
    t_push = 1'b0;
    t_pop = 1'b0;
    r_push = 1'b0;
    r_pop = 1'b0;
    ev = 4'h0;
    clr = 4'h0;
    wnew = s_r.rword;
    s_nxt.ack = bus_go;

    // receive strobe per edge mode
    if (mode) begin
      rx_evt = (dcp & diep) & ~(dc & input_window_enable);
    end else begin
      rx_evt = (~dc & input_window_enable) & ~(~dcp & diep);
    end

    // transmit advance per edge mode; window close with clock low keeps the bit
    if (mode) begin
      tx_adv = dc & ~dcp & output_window_enable & (s_r.wbits < asc_pkg::BITS_PER_WINDOW);
    end else begin
      tx_adv = (dcp & doep) & ~(dc & output_window_enable);
    end

    // window bit counter restarts when the output window opens
    if (output_window_enable & ~doep) begin
      s_nxt.wbits = 4'h0;
    end else if (tx_adv) begin
      s_nxt.wbits = s_r.wbits + 4'h1;
    end

    // output drive follows the window; forced off while held in reset
    s_nxt.oe = output_window_enable & ~hold;

    // transmit shifter: data words from the fifo, flags when it is empty
    if (tx_adv) begin
      if (mode) begin
        s_nxt.tout = s_r.tsh[0];
      end
      if (s_r.tleft > 4'h1) begin
        s_nxt.tsh = {1'b0, s_r.tsh[8:1]};
        s_nxt.tleft = s_r.tleft - 4'h1;
      end else if (s_r.tcnt != 3'h0) begin
        s_nxt.tsh = s_r.txm[s_r.trp];
        s_nxt.tleft = len;
        t_pop = 1'b1;
      end else begin
        s_nxt.tsh = {1'b0, asc_pkg::FLAG_WORD};
        s_nxt.tleft = asc_pkg::LEN_SHORT;
      end
    end
    if (!mode) begin
      s_nxt.tout = s_nxt.tsh[0];
    end

    // receiver: hunt for a flag, then assemble words of the selected length
    if (rx_evt) begin
      s_nxt.hunt = {din, s_r.hunt[7:1]};
      if (!s_r.framed) begin
        if (s_nxt.hunt == asc_pkg::FLAG_WORD) begin
          s_nxt.framed = 1'b1;
          s_nxt.rbits = 4'h0;
          ev[asc_pkg::IRQ_FRAMED] = 1'b1;
        end
      end else begin
        wnew = {din, s_r.rword[8:1]};
        if (s_r.rbits + 4'h1 == len) begin
          s_nxt.rbits = 4'h0;
          s_nxt.rword = '0;
          if (len == asc_pkg::LEN_SHORT) begin
            wnew = {1'b0, wnew[8:1]};
          end
          // a flag between eight-bit words carries no data
          if (!(len == asc_pkg::LEN_SHORT && wnew[7:0] == asc_pkg::FLAG_WORD)) begin
            r_push = 1'b1;
          end
        end else begin
          s_nxt.rbits = s_r.rbits + 4'h1;
          s_nxt.rword = wnew;
        end
      end
    end

    // register writes
    if (bus_go && we_i) begin
      if (adr_i == asc_pkg::ADR_CTRL) begin
        if (sel_i[0]) begin
          s_nxt.ctrl = dat_i[4:0];
        end
      end else if (adr_i == asc_pkg::ADR_TXDATA) begin
        // write to a full fifo is dropped; software polls the status depth
        t_push = sel_i[0] & (s_r.tcnt != 3'(asc_pkg::FIFO_DEPTH));
      end else if (adr_i == asc_pkg::ADR_IRQ_MASK) begin
        if (sel_i[0]) begin
          s_nxt.imask = dat_i[3:0];
        end
      end
    end

    // register reads; data is registered with the acknowledge
    s_nxt.rdat = 32'h0000_0000;
    if (bus_go && !we_i) begin
      if (adr_i == asc_pkg::ADR_CTRL) begin
        s_nxt.rdat = {27'h0, s_r.ctrl};
      end else if (adr_i == asc_pkg::ADR_STATUS) begin
        s_nxt.rdat = {24'h0, s_r.rcnt, s_r.tcnt, s_r.tcnt >= asc_pkg::BACKLOG_LEVEL,
                      s_r.framed};
      end else if (adr_i == asc_pkg::ADR_RXDATA) begin
        // an empty fifo reads zero so stale words never leak after a flush
        s_nxt.rdat = {22'h0, s_r.rcnt != 3'h0, (s_r.rcnt != 3'h0) ? s_r.rxm[s_r.rrp] : 9'h000};
        r_pop = s_r.rcnt != 3'h0;
      end else if (adr_i == asc_pkg::ADR_IRQ_STAT) begin
        s_nxt.rdat = {28'h0, s_r.ists};
        clr = s_r.ists;
      end else if (adr_i == asc_pkg::ADR_IRQ_MASK) begin
        s_nxt.rdat = {28'h0, s_r.imask};
      end
    end

    // tx fifo
    if (t_push) begin
      s_nxt.txm[s_r.twp] = dat_i[8:0];
      s_nxt.twp = s_r.twp + 2'h1;
    end
    if (t_pop) begin
      s_nxt.trp = s_r.trp + 2'h1;
      if (s_r.tcnt == 3'h1 && !t_push) begin
        ev[asc_pkg::IRQ_TX_EMPTY] = 1'b1;
      end
    end
    s_nxt.tcnt = s_r.tcnt + 3'(t_push) - 3'(t_pop);

    // rx fifo; when full the newest slot is overwritten
    if (r_push) begin
      ev[asc_pkg::IRQ_RX_WORD] = 1'b1;
      if (s_r.rcnt == 3'(asc_pkg::FIFO_DEPTH) && !r_pop) begin
        s_nxt.rxm[s_r.rwp - 2'h1] = wnew;
        ev[asc_pkg::IRQ_OVERRUN] = 1'b1;
        r_push = 1'b0;
      end else begin
        s_nxt.rxm[s_r.rwp] = wnew;
        s_nxt.rwp = s_r.rwp + 2'h1;
      end
    end
    if (r_pop) begin
      s_nxt.rrp = s_r.rrp + 2'h1;
    end
    s_nxt.rcnt = s_r.rcnt + 3'(r_push) - 3'(r_pop);

    // sticky events; a new event wins over the read clear
    s_nxt.ists = (s_r.ists & ~clr) | ev;

    // device reset pin holds the channel idle
    if (hold) begin
      s_nxt.twp = 2'h0;
      s_nxt.trp = 2'h0;
      s_nxt.tcnt = 3'h0;
      s_nxt.rwp = 2'h0;
      s_nxt.rrp = 2'h0;
      s_nxt.rcnt = 3'h0;
      s_nxt.framed = 1'b0;
      s_nxt.hunt = 8'h00;
      s_nxt.rbits = 4'h0;
      s_nxt.rword = '0;
      s_nxt.tsh = {1'b0, asc_pkg::FLAG_WORD};
      s_nxt.tleft = asc_pkg::LEN_SHORT;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.tsh <= {1'b0, asc_pkg::FLAG_WORD};
      s_r.tleft <= asc_pkg::LEN_SHORT;
      s_r.ctrl <= asc_pkg::CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dat_o = s_r.rdat;
  assign ack_o = s_r.ack;
  assign sync_serial_out_o = s_r.tout;
  assign sync_serial_out_oe_n_o = ~s_r.oe;
  // flags are low while held; backlog high means fewer than two words queued
  assign tx_backlog_flag_o = reset_n_i & (s_r.tcnt < asc_pkg::BACKLOG_LEVEL);
  assign rx_framing_flag_o = reset_n_i & s_r.framed;
  assign irq_o = |(s_r.ists & s_r.imask);

endmodule : asc_port
`default_nettype wire

// file: asc_port_monitor.sv
// assertion checker watching the channel port pins
`timescale 1ns/10ps
`default_nettype none
module asc_port_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic reset_n_i,
  input wire logic sync_bit_clock_i,
  input wire logic output_window_enable_i,
  input wire logic rate_reference_clock_i,
  input wire logic sync_serial_out_o,
  input wire logic sync_serial_out_oe_n_o,
  input wire logic x16_sampling_clock_o,
  input wire logic tx_backlog_flag_o,
  input wire logic rx_framing_flag_o
);
  // ----
  // cycles since the last link pin change
  // ----
  logic [3:0] ev_r;
  logic [3:0] rf_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // start at zero: the synchroniser may see a stale edge just after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_r <= 4'h0;
      rf_r <= 4'h0;
    end else begin
      ev_r <= ($changed(sync_bit_clock_i) || $changed(output_window_enable_i)
        || $changed(reset_n_i)) ? 4'h0 : ev_r + {3'h0, ev_r != 4'hF};
      rf_r <= $rose(rate_reference_clock_i) ? 4'h0 : rf_r + {3'h0, rf_r != 4'hF};
    end
  end
  // ----
  // properties
  // ----
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_answer; (cyc_i && stb_i && !ack_o) |=> ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack late");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_flags_rst; !reset_n_i |-> !tx_backlog_flag_o && !rx_framing_flag_o; endproperty
  a_flags_rst: assert property (p_flags_rst) else $error("flags high in reset");
  property p_oe_rst; !reset_n_i ##1 !reset_n_i |-> sync_serial_out_oe_n_o; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("output driven in reset");
  property p_oe_on; (output_window_enable_i && reset_n_i)[*6] |-> !sync_serial_out_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven");
  property p_oe_off; (!output_window_enable_i)[*6] |-> sync_serial_out_oe_n_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven late");
  property p_x16_pulse; x16_sampling_clock_o |=> !x16_sampling_clock_o; endproperty
  a_x16_pulse: assert property (p_x16_pulse) else $error("x16 pulse too wide");
  property p_x16_ref; x16_sampling_clock_o |-> rf_r <= 4'h8; endproperty
  a_x16_ref: assert property (p_x16_ref) else $error("x16 without reference");
  property p_out_edge; $changed(sync_serial_out_o) |-> ev_r <= 4'h8; endproperty
  a_out_edge: assert property (p_out_edge) else $error("output moved idle");
  property p_frm_keep; $fell(rx_framing_flag_o) |-> !reset_n_i; endproperty
  a_frm_keep: assert property (p_frm_keep) else $error("framing dropped");
  property p_frm_rise; $rose(rx_framing_flag_o) |-> ev_r <= 4'h8; endproperty
  a_frm_rise: assert property (p_frm_rise) else $error("framing without bit");
endmodule : asc_port_monitor
bind asc_port asc_port_monitor u_asc_port_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .reset_n_i(reset_n_i),
  .sync_bit_clock_i(sync_bit_clock_i), .output_window_enable_i(output_window_enable_i),
  .rate_reference_clock_i(rate_reference_clock_i), .sync_serial_out_o(sync_serial_out_o),
  .sync_serial_out_oe_n_o(sync_serial_out_oe_n_o), .x16_sampling_clock_o(x16_sampling_clock_o),
  .tx_backlog_flag_o(tx_backlog_flag_o), .rx_framing_flag_o(rx_framing_flag_o));
`default_nettype wire

// file: asc_link_model.sv
// behavioural link partner: data clock, windows, serial data
`timescale 1ns/10ps
`default_nettype none
module asc_link_model (
  input wire logic clk_i,
  input wire logic [15:0] pat_i,
  input wire logic dout_i,
  output logic dc_o,
  output logic die_o,
  output logic doe_o,
  output logic din_o,
  output logic seen_o
);
  logic [15:0] sr_r = 16'h0;
  initial begin
    dc_o = 1'b1;
    die_o = 1'b0;
    doe_o = 1'b0;
    din_o = 1'b0;
    seen_o = 1'b0;
  end
  // ----
  // one window of n bits, lsb first, 2 MHz data clock
  // ----
  task automatic frame(input logic [47:0] v, input int n, input logic input_window_enable, input logic output_window_enable);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      din_o <= v[i];
      die_o <= input_window_enable;
      doe_o <= output_window_enable;
      repeat (25) @(posedge clk_i);
      dc_o <= 1'b0;
      repeat (25) @(posedge clk_i);
      sr_r = {dout_i, sr_r[15:1]};
      if (sr_r === pat_i) seen_o <= 1'b1;
      // closing while the clock is low keeps the pending bit
      if (i == n - 1) begin
        die_o <= 1'b0;
        doe_o <= 1'b0;
      end else begin
        dc_o <= 1'b1;
      end
    end
    repeat (25) @(posedge clk_i);
    dc_o <= 1'b1;
    din_o <= ~din_o; // no stale level between frames
  endtask : frame
endmodule : asc_link_model
`default_nettype wire

// file: asc_port_test.sv
// self-checking bench for the synchronous channel port
`timescale 1ns/10ps
`default_nettype none
module asc_port_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic rstn = 1'b0;
  logic ref_clk = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, dc, input_window_enable, output_window_enable, din, dout, oe_n, x16, txb, rxf, irq, seen;
  int err_total = 0;
  int cmp_count = 0;
  int x16_cnt = 0;
  int ref_cnt = 0;
  int ref_div = 0;
  int rate_tab [8] = '{0, 614400, 307200, 153600, 76800, 38400, 19200, 4800};
  // ----
  // clocks and x16 pulse count
  // ----
  always #5 clk_i = ~clk_i;
  // reference near 4.17 MHz; divided counts depend on edges, not on rate
  always @(posedge clk_i) begin
    ref_div <= (ref_div == 11) ? 0 : ref_div + 1;
    if (ref_div == 11) ref_clk <= ~ref_clk;
    if (ref_div == 11 && !ref_clk) ref_cnt <= ref_cnt + 1;
    if (x16 === 1'b1) x16_cnt <= x16_cnt + 1;
  end
  asc_port u_asc_port (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .reset_n_i(rstn),
    .sync_bit_clock_i(dc), .input_window_enable_i(input_window_enable), .output_window_enable_i(output_window_enable),
    .sync_serial_in_i(din), .sync_serial_out_o(dout), .sync_serial_out_oe_n_o(oe_n),
    .rate_reference_clock_i(ref_clk), .x16_sampling_clock_o(x16),
    .tx_backlog_flag_o(txb), .rx_framing_flag_o(rxf), .irq_o(irq));
  // a released output line floats to its pull-up level at the partner
  asc_link_model u_asc_link_model (.clk_i(clk_i), .pat_i(16'hC33C), .dout_i(oe_n ? 1'b1 : dout),
    .dc_o(dc), .die_o(input_window_enable), .doe_o(output_window_enable), .din_o(din), .seen_o(seen));
  // ----
  // tasks
  // ----
  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask : wb
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wait_ref;
    int s;
    int n;
    s = ref_cnt;
    n = 0;
    while (ref_cnt < s + 200 && n < 10000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 10000) begin
      err_total++;
      end_sim();
    end
  endtask : wait_ref
  initial begin
    logic [8:0] w;
    int d;
    int e;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    chk({30'h0, oe_n, txb | rxf}, 32'h2);
    @(posedge clk_i);
    rstn <= 1'b1;
    tick(2);
    chk({30'h0, txb, rxf}, 32'h2);
    rd(asc_pkg::ADR_CTRL, 32'h0);
    rd(asc_pkg::ADR_STATUS, 32'h0);
    rd(5'h1C, 32'h0);
    wb(1'b1, asc_pkg::ADR_IRQ_MASK, 32'h2);
    rd(asc_pkg::ADR_IRQ_MASK, 32'h2);
    u_asc_link_model.frame(48'h55, 8, 1'b1, 1'b0);
    rd(asc_pkg::ADR_RXDATA, 32'h0);
    u_asc_link_model.frame(48'h7E, 8, 1'b0, 1'b0);
    tick(8);
    chk({31'h0, rxf}, 32'h0);
    u_asc_link_model.frame(48'h7E, 8, 1'b1, 1'b0);
    tick(8);
    chk({30'h0, rxf, irq}, 32'h3);
    wb(1'b0, asc_pkg::ADR_IRQ_STAT, 32'h0);
    chk(q & 32'h2, 32'h2);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    // both edge modes with both word lengths; word events stay masked
    for (int k = 0; k < 4; k++) begin
      w = k[1] ? 9'h1A5 : 9'h05A;
      wb(1'b1, asc_pkg::ADR_CTRL, {27'h0, k[1], 3'h0, k[0]});
      u_asc_link_model.frame({39'h0, w}, k[1] ? 9 : 8, 1'b1, 1'b0);
      rd(asc_pkg::ADR_RXDATA, {22'h0, 1'b1, w});
    end
    chk({31'h0, irq}, 32'h0);
    u_asc_link_model.frame(48'h155, 9, 1'b1, 1'b0);
    rstn <= 1'b0;
    tick(2);
    chk({30'h0, txb, rxf}, 32'h0);
    rd(asc_pkg::ADR_RXDATA, 32'h0);
    rstn <= 1'b1;
    tick(2);
    chk({30'h0, txb, rxf}, 32'h2);
    // two words out through a window split in mid-word
    wb(1'b1, asc_pkg::ADR_CTRL, 32'h0);
    wb(1'b1, asc_pkg::ADR_TXDATA, 32'h3C);
    wb(1'b1, asc_pkg::ADR_TXDATA, 32'hC3);
    chk({31'h0, txb}, 32'h0);
    u_asc_link_model.frame(48'h0, 12, 1'b0, 1'b1);
    u_asc_link_model.frame(48'h0, 28, 1'b0, 1'b1);
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, txb}, 32'h1);
    rd(asc_pkg::ADR_IRQ_STAT, 32'h9); // rx word and tx emptied events kept
    // edge mode high: 17 clock rises in one window, only eight advance
    wb(1'b1, asc_pkg::ADR_CTRL, 32'h1);
    wb(1'b1, asc_pkg::ADR_TXDATA, 32'h11);
    wb(1'b1, asc_pkg::ADR_TXDATA, 32'h22);
    u_asc_link_model.frame(48'h0, 18, 1'b0, 1'b1);
    rd(asc_pkg::ADR_STATUS, 32'h4);
    // x16 pulses per 200 reference edges, one count of slack
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, asc_pkg::ADR_CTRL, 32'(c) << 1);
      tick(30);
      d = x16_cnt;
      wait_ref();
      d = x16_cnt - d;
      e = (c == 0) ? 200 : 200 * rate_tab[c] / 4096000;
      chk({31'h0, d >= e - 1 && d <= e + 1}, 32'h1);
    end
    end_sim();
  end
endmodule : asc_port_test
`default_nettype wire
